// [hw/gmx_map.svh]
// Pin positions, claim masks, role codes and timing for the GPIO pin mux
`ifndef GMX_MAP_SVH
`define GMX_MAP_SVH
`define GMX_PINS             32
`define GMX_PRESENT_MASK     32'hE1F8_FFFF
`define GMX_HOST_MASK        32'h01F8_FFFF
`define GMX_FAST_MASK        32'h0000_F000
`define GMX_SPI_MASK         32'h0000_0F00
`define GMX_UART_MASK        32'h0000_00C0
`define GMX_EE_MASK          32'hC000_0000
`define GMX_OTG_MASK         32'h2000_0000
`define GMX_PIN_EE_HI        31
`define GMX_PIN_EE_LO        30
`define GMX_PIN_OTG_ID       29
`define GMX_PIN_HOST_INT     24
`define GMX_PIN_HOST_RD      23
`define GMX_PIN_HOST_WR      22
`define GMX_PIN_HOST_CS      21
`define GMX_PIN_HOST_A1      20
`define GMX_PIN_HOST_A0      19
`define GMX_PIN_FS_CTS       15
`define GMX_PIN_FS_RTS       14
`define GMX_PIN_FS_RXD       13
`define GMX_PIN_FS_TXD       12
`define GMX_PIN_SPI_MOSI     11
`define GMX_PIN_SPI_SCK      10
`define GMX_PIN_SPI_SEL      9
`define GMX_PIN_SPI_MISO     8
`define GMX_PIN_UART_TX      7
`define GMX_PIN_UART_RX      6
`define GMX_ROLE_UNUSED      2'h0
`define GMX_ROLE_HOST        2'h1
`define GMX_ROLE_PERIPH      2'h2
`define GMX_ROLE_OTG         2'h3
`define GMX_IN_DELAY_PS      41667
`define GMX_CLK_PERIOD_PS    50000
`define GMX_IN_DELAY_CYC     ((`GMX_IN_DELAY_PS / `GMX_CLK_PERIOD_PS) < 1 ? 1 : \
                              (`GMX_IN_DELAY_PS / `GMX_CLK_PERIOD_PS))
`endif

// [hw/gmx_pkg.sv]
// Types for the GPIO pin mux
package gmx_pkg;
  typedef logic [1:0] gmx_role_type;
  typedef struct packed {
    logic [31:0]  pin_out;
    logic [31:0]  pin_oe;
    logic [31:0]  gpio_in;
    logic [31:0]  gpio_avail;
    logic         host_rd_n;
    logic         host_wr_n;
    logic         host_cs_n;
    logic [1:0]   host_addr;
    logic [15:0]  host_data_in;
    logic         fs_cts;
    logic         fs_rxd;
    logic         spi_mosi_in;
    logic         spi_sck_in;
    logic         spi_sel_n;
    logic         spi_miso_in;
    logic         uart_rx;
    logic         ee_scl_in;
    logic         ee_sda_in;
    logic         otg_id;
    gmx_role_type p1_role;
    gmx_role_type p2_role;
    logic         role_err;
    logic         sel_conflict;
  } gmx_state_type;
endpackage

// [hw/gmx_pin_mux.sv]
// Shared GPIO pin multiplexer with interface coexistence and USB role checks
`timescale 1ns/1ps
`include "gmx_map.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// [RULE1] Host port excludes fast serial, SPI, UART
// [RULE2] EEPROM and OTG ID pins always usable
// [RULE3] Pin changes seen within two core cycles
// [RULE4] Inputs captured through one flip-flop only
// [RULE5] 25 GPIO; claimed pins leave the pool
// [RULE6] OTG role only on first USB port
// [RULE7] Both USB port roles set independently
// [RULE8] Software drives unused GPIO as low outputs
// [RULE9] Host port control and data pin placement
// [RULE10] Fixed pins for serial, SPI, UART, EEPROM, ID
// [RULE11] Unclaimed pins follow software GPIO control
module gmx_pin_mux (
  input  wire logic                 clk,             // Core clock
  input  wire logic                 nrst,            // Async reset, active low
  input  wire logic [31:0]          pin_in,          // Pad input levels
  output logic      [31:0]          pin_out,         // Pad output levels
  output logic      [31:0]          pin_oe,          // Pad output enables
  input  wire logic                 sel_host,        // Enable parallel_host_port
  input  wire logic                 sel_fast,        // Enable fast_serial_port
  input  wire logic                 sel_spi,         // Enable SPI port
  input  wire logic                 sel_uart,        // Enable UART
  input  wire logic                 sel_eeprom,      // Enable EEPROM lines
  input  wire logic                 sel_otg_id,      // Enable otg_role_id_pin
  input  wire logic [31:0]          gpio_dir,        // Software direction, 1 = out
  input  wire logic [31:0]          gpio_out,        // Software output level
  output logic      [31:0]          gpio_in,         // Captured pin levels
  output logic      [31:0]          gpio_avail,      // Pins free for GPIO
  input  wire logic                 host_int,        // Host port interrupt out
  input  wire logic [15:0]          host_data_out,   // Host port read data
  output logic                      host_read_strobe_n,  // From host
  output logic                      host_write_strobe_n, // From host
  output logic                      host_select_n,   // From host
  output logic      [1:0]           host_addr,       // From host
  output logic      [15:0]          host_data_in,    // Host write data
  output logic                      fs_cts,          // Fast serial clear to send
  input  wire logic                 fs_rts,          // Fast serial request to send
  output logic                      fs_rxd,          // Fast serial receive
  input  wire logic                 fs_txd,          // Fast serial transmit
  input  wire logic                 spi_master,      // 1 = SPI master
  input  wire logic                 spi_mosi_out,    // Master data out
  input  wire logic                 spi_sck_out,     // Master clock out
  input  wire logic                 spi_miso_out,    // Slave data out
  output logic                      spi_mosi_in,     // Slave data in
  output logic                      spi_sck_in,      // Slave clock in
  output logic                      spi_select_in_n, // Slave select in
  output logic                      spi_miso_in,     // Master data in
  input  wire logic                 uart_tx,         // UART transmit
  output logic                      uart_rx,         // UART receive
  input  wire logic                 ee_large,        // Swap clock/data pins
  input  wire logic                 ee_scl_low,      // Pull EEPROM clock low
  input  wire logic                 ee_sda_low,      // Pull EEPROM data low
  output logic                      ee_scl_in,       // EEPROM clock level
  output logic                      ee_sda_in,       // EEPROM data level
  output logic                      otg_role_id_pin, // OTG ID level
  input  wire gmx_pkg::gmx_role_type port1_role,     // first_usb_port request
  input  wire gmx_pkg::gmx_role_type port2_role,     // second_usb_port request
  output gmx_pkg::gmx_role_type     port1_role_eff,  // Granted first port role
  output gmx_pkg::gmx_role_type     port2_role_eff,  // Granted second port role
  output logic                      role_err,        // OTG refused on second port
  output logic                      sel_conflict     // Host port overrode others
);

  localparam int IN_DELAY_CYC = `GMX_IN_DELAY_CYC;

  gmx_pkg::gmx_state_type state_reg;
  gmx_pkg::gmx_state_type state_next;
  logic        en_host;
  logic        en_fast;
  logic        en_spi;
  logic        en_uart;
  logic [31:0] claim;
  logic [31:0] avail;
  logic [31:0] gp_out;
  logic [31:0] gp_oe;
  logic        ee_hi_low;
  logic        ee_lo_low;

  //////////////////////////////////////////////////////////////////////////////
  // Interface enables and claim mask
  assign en_host = sel_host;
  assign en_fast = sel_fast & ~sel_host; // RULE1
  assign en_spi  = sel_spi  & ~sel_host; // RULE1
  assign en_uart = sel_uart & ~sel_host; // RULE1
  assign claim = ({32{en_host}}    & `GMX_HOST_MASK) |
                 ({32{en_fast}}    & `GMX_FAST_MASK) |
                 ({32{en_spi}}     & `GMX_SPI_MASK)  |
                 ({32{en_uart}}    & `GMX_UART_MASK) |
                 ({32{sel_eeprom}} & `GMX_EE_MASK)   |
                 ({32{sel_otg_id}} & `GMX_OTG_MASK);
  assign avail = `GMX_PRESENT_MASK & ~claim; // RULE5
  assign ee_hi_low = ee_large ? ee_sda_low : ee_scl_low;
  assign ee_lo_low = ee_large ? ee_scl_low : ee_sda_low;

  //////////////////////////////////////////////////////////////////////////////
  // Plain GPIO drive for every free pin
  for (genvar i = 0; i < `GMX_PINS; i++) begin : g_gpio
    assign gp_oe[i]  = avail[i] & gpio_dir[i];              // RULE11
    assign gp_out[i] = avail[i] & gpio_dir[i] & gpio_out[i]; // RULE11
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state: pin overlay, input capture, role checks
  always_comb begin
    state_next = state_reg;
    state_next.pin_out    = gp_out;
    state_next.pin_oe     = gp_oe;
    state_next.gpio_in    = pin_in & `GMX_PRESENT_MASK; // RULE3 RULE4
    state_next.gpio_avail = avail;
    state_next.sel_conflict = sel_host & (sel_fast | sel_spi | sel_uart); // RULE1
    // Parallel host port
    if (en_host) begin
      state_next.pin_out[`GMX_PIN_HOST_INT] = host_int; // RULE9
      state_next.pin_oe[`GMX_PIN_HOST_INT]  = 1'b1;     // RULE9
      state_next.pin_out[15:0] = host_data_out;         // RULE9
      state_next.pin_oe[15:0]  = {16{~pin_in[`GMX_PIN_HOST_CS] &
                                     ~pin_in[`GMX_PIN_HOST_RD]}}; // RULE9
    end
    state_next.host_rd_n    = en_host ? pin_in[`GMX_PIN_HOST_RD] : 1'b1;
    state_next.host_wr_n    = en_host ? pin_in[`GMX_PIN_HOST_WR] : 1'b1;
    state_next.host_cs_n    = en_host ? pin_in[`GMX_PIN_HOST_CS] : 1'b1;
    state_next.host_addr    = en_host ?
                              {pin_in[`GMX_PIN_HOST_A1], pin_in[`GMX_PIN_HOST_A0]} : 2'h0;
    state_next.host_data_in = en_host ? pin_in[15:0] : 16'h0000;
    // Fast serial port
    if (en_fast) begin
      state_next.pin_out[`GMX_PIN_FS_RTS] = fs_rts; // RULE10
      state_next.pin_oe[`GMX_PIN_FS_RTS]  = 1'b1;
      state_next.pin_out[`GMX_PIN_FS_TXD] = fs_txd; // RULE10
      state_next.pin_oe[`GMX_PIN_FS_TXD]  = 1'b1;
    end
    state_next.fs_cts = en_fast ? pin_in[`GMX_PIN_FS_CTS] : 1'b1;
    state_next.fs_rxd = en_fast ? pin_in[`GMX_PIN_FS_RXD] : 1'b1;
    // SPI port, master drives clock and data, slave drives MISO when selected
    if (en_spi) begin
      state_next.pin_out[`GMX_PIN_SPI_MOSI] = spi_mosi_out; // RULE10
      state_next.pin_oe[`GMX_PIN_SPI_MOSI]  = spi_master;
      state_next.pin_out[`GMX_PIN_SPI_SCK]  = spi_sck_out;
      state_next.pin_oe[`GMX_PIN_SPI_SCK]   = spi_master;
      state_next.pin_out[`GMX_PIN_SPI_MISO] = spi_miso_out;
      state_next.pin_oe[`GMX_PIN_SPI_MISO]  = ~spi_master & ~pin_in[`GMX_PIN_SPI_SEL];
    end
    state_next.spi_mosi_in = en_spi & pin_in[`GMX_PIN_SPI_MOSI];
    state_next.spi_sck_in  = en_spi & pin_in[`GMX_PIN_SPI_SCK];
    state_next.spi_sel_n   = ~en_spi | pin_in[`GMX_PIN_SPI_SEL];
    state_next.spi_miso_in = en_spi & pin_in[`GMX_PIN_SPI_MISO];
    // UART
    if (en_uart) begin
      state_next.pin_out[`GMX_PIN_UART_TX] = uart_tx; // RULE10
      state_next.pin_oe[`GMX_PIN_UART_TX]  = 1'b1;
    end
    state_next.uart_rx = en_uart ? pin_in[`GMX_PIN_UART_RX] : 1'b1;
    // EEPROM open-drain lines, independent of every other selection
    if (sel_eeprom) begin
      state_next.pin_out[`GMX_PIN_EE_HI] = 1'b0;      // RULE2 RULE10
      state_next.pin_oe[`GMX_PIN_EE_HI]  = ee_hi_low; // RULE2
      state_next.pin_out[`GMX_PIN_EE_LO] = 1'b0;
      state_next.pin_oe[`GMX_PIN_EE_LO]  = ee_lo_low; // RULE2
    end
    state_next.ee_scl_in = ~sel_eeprom |
                           pin_in[ee_large ? `GMX_PIN_EE_LO : `GMX_PIN_EE_HI];
    state_next.ee_sda_in = ~sel_eeprom |
                           pin_in[ee_large ? `GMX_PIN_EE_HI : `GMX_PIN_EE_LO];
    state_next.otg_id = sel_otg_id ? pin_in[`GMX_PIN_OTG_ID] : 1'b1; // RULE2 RULE10
    // USB port roles
    state_next.p1_role  = port1_role; // RULE7
    state_next.role_err = (port2_role == `GMX_ROLE_OTG); // RULE6
    state_next.p2_role  = (port2_role == `GMX_ROLE_OTG) ? `GMX_ROLE_UNUSED
                                                         : port2_role; // RULE6 RULE7
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.host_rd_n <= 1'b1;
      state_reg.host_wr_n <= 1'b1;
      state_reg.host_cs_n <= 1'b1;
      state_reg.fs_cts    <= 1'b1;
      state_reg.fs_rxd    <= 1'b1;
      state_reg.spi_sel_n <= 1'b1;
      state_reg.uart_rx   <= 1'b1;
      state_reg.ee_scl_in <= 1'b1;
      state_reg.ee_sda_in <= 1'b1;
      state_reg.otg_id    <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pin_out             = state_reg.pin_out;
  assign pin_oe              = state_reg.pin_oe;
  assign gpio_in             = state_reg.gpio_in;
  assign gpio_avail          = state_reg.gpio_avail;
  assign host_read_strobe_n  = state_reg.host_rd_n;
  assign host_write_strobe_n = state_reg.host_wr_n;
  assign host_select_n       = state_reg.host_cs_n;
  assign host_addr           = state_reg.host_addr;
  assign host_data_in        = state_reg.host_data_in;
  assign fs_cts              = state_reg.fs_cts;
  assign fs_rxd              = state_reg.fs_rxd;
  assign spi_mosi_in         = state_reg.spi_mosi_in;
  assign spi_sck_in          = state_reg.spi_sck_in;
  assign spi_select_in_n     = state_reg.spi_sel_n;
  assign spi_miso_in         = state_reg.spi_miso_in;
  assign uart_rx             = state_reg.uart_rx;
  assign ee_scl_in           = state_reg.ee_scl_in;
  assign ee_sda_in           = state_reg.ee_sda_in;
  assign otg_role_id_pin     = state_reg.otg_id;
  assign port1_role_eff      = state_reg.p1_role;
  assign port2_role_eff      = state_reg.p2_role;
  assign role_err            = state_reg.role_err;
  assign sel_conflict        = state_reg.sel_conflict;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions and covers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_host_exclusive: assert property (nrst && sel_host |=> // RULE1
    pin_oe[15:0] == ($past(!pin_in[`GMX_PIN_HOST_CS] && !pin_in[`GMX_PIN_HOST_RD]) ?
                     16'hFFFF : 16'h0000))
    else $error("host port shares pins with another port");
  a_eeprom_kept: assert property (nrst && sel_eeprom && !ee_large |=> // RULE2
    pin_oe[`GMX_PIN_EE_HI] == $past(ee_scl_low) && !pin_out[`GMX_PIN_EE_HI])
    else $error("eeprom clock pin not under eeprom control");
  a_sample_delay: assert property (nrst |-> ##IN_DELAY_CYC // RULE3
    (gpio_in == ($past(pin_in, IN_DELAY_CYC) & `GMX_PRESENT_MASK)))
    else $error("gpio input not seen in time");
  a_single_stage: assert property (nrst && $changed(pin_in[5]) |=> // RULE4
    gpio_in[5] == $past(pin_in[5]))
    else $error("gpio input not captured by one stage");
  a_pool_shrinks: assert property (nrst && sel_host |=> gpio_avail[15:0] == 16'h0000 // RULE5
    && gpio_avail[24:19] == 6'h00)
    else $error("claimed pins still offered as gpio");
  a_port2_no_otg: assert property (nrst && port2_role == `GMX_ROLE_OTG |=> // RULE6
    port2_role_eff == `GMX_ROLE_UNUSED && role_err)
    else $error("otg granted on second port");
  a_port1_free: assert property (nrst |=> port1_role_eff == $past(port1_role)) // RULE7
    else $error("first port role not granted");
  a_host_int_pin: assert property (nrst && sel_host |=> // RULE9
    pin_oe[`GMX_PIN_HOST_INT] && pin_out[`GMX_PIN_HOST_INT] == $past(host_int))
    else $error("host interrupt not on its pin");
  a_uart_tx_pin: assert property (nrst && sel_uart && !sel_host |=> // RULE10
    pin_oe[`GMX_PIN_UART_TX] && pin_out[`GMX_PIN_UART_TX] == $past(uart_tx))
    else $error("uart transmit not on its pin");
  a_gpio_free: assert property (nrst && !sel_host |=> // RULE11
    pin_oe[5] == $past(gpio_dir[5]) && pin_out[5] == $past(gpio_dir[5] & gpio_out[5]))
    else $error("free pin not under software control");

  c_host_read: cover property (sel_host ##1 !host_select_n && !host_read_strobe_n);
  c_all_serial: cover property (sel_fast && sel_spi && sel_uart && !sel_host);
  c_conflict: cover property (sel_conflict);
  c_otg_refused: cover property (role_err);

endmodule // gmx_pin_mux

// [tb/gmx_pin_partner.sv]
// Behavioural far side that drives or releases the shared pads
`timescale 1ns/1ps

module gmx_pin_partner (
  input  wire logic        clk,     // Core clock
  input  wire logic [31:0] pin_out, // Pad levels from the mux
  input  wire logic [31:0] pin_oe,  // Pad enables from the mux
  input  wire logic [31:0] ext_en,  // Far side drives this pad
  input  wire logic [31:0] ext_val, // Far side level
  output logic      [31:0] pin_in   // Resolved pad level
);
  logic [31:0] last_reg = 32'h0000_0000;

  // Remember the last level so released lines below pad 30 never hold it
  always_ff @(posedge clk) begin
    last_reg <= pin_in;
  end

  // Mux wins, then far side; EEPROM pads pull up, others flip
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (i >= 30) pin_in[i] = 1'b1;
      else pin_in[i] = ~last_reg[i];
    end
  end
endmodule // gmx_pin_partner

// [tb/tb_top.sv]
// Self-checking bench for the GPIO pin mux
`timescale 1ns/1ps
`include "gmx_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [31:0] pin_in, pin_out, pin_oe, gpio_dir, gpio_out, gpio_in, gpio_avail, ext_en, ext_val;
  logic        sel_host, sel_fast, sel_spi, sel_uart, sel_eeprom, sel_otg_id, host_int;
  logic [15:0] host_data_out, host_data_in;
  logic        host_read_strobe_n, host_write_strobe_n, host_select_n;
  logic [1:0]  host_addr;
  logic        fs_cts, fs_rts, fs_rxd, fs_txd, spi_master, spi_mosi_out, spi_sck_out;
  logic        spi_miso_out, spi_mosi_in, spi_sck_in, spi_select_in_n, spi_miso_in;
  logic        uart_tx, uart_rx, ee_large, ee_scl_low, ee_sda_low, ee_scl_in, ee_sda_in;
  logic        otg_role_id_pin, role_err, sel_conflict;
  gmx_pkg::gmx_role_type port1_role, port2_role, port1_role_eff, port2_role_eff;
  int          n_fail = 0;
  int          n_tests = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, design and far side
  always #25 clk = ~clk;
  gmx_pin_mux i_dut (
    .clk(clk), .nrst(nrst), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .sel_host(sel_host), .sel_fast(sel_fast), .sel_spi(sel_spi), .sel_uart(sel_uart),
    .sel_eeprom(sel_eeprom), .sel_otg_id(sel_otg_id), .gpio_dir(gpio_dir),
    .gpio_out(gpio_out), .gpio_in(gpio_in), .gpio_avail(gpio_avail), .host_int(host_int),
    .host_data_out(host_data_out), .host_read_strobe_n(host_read_strobe_n),
    .host_write_strobe_n(host_write_strobe_n), .host_select_n(host_select_n),
    .host_addr(host_addr), .host_data_in(host_data_in), .fs_cts(fs_cts), .fs_rts(fs_rts),
    .fs_rxd(fs_rxd), .fs_txd(fs_txd), .spi_master(spi_master),
    .spi_mosi_out(spi_mosi_out), .spi_sck_out(spi_sck_out), .spi_miso_out(spi_miso_out),
    .spi_mosi_in(spi_mosi_in), .spi_sck_in(spi_sck_in), .spi_select_in_n(spi_select_in_n),
    .spi_miso_in(spi_miso_in), .uart_tx(uart_tx), .uart_rx(uart_rx), .ee_large(ee_large),
    .ee_scl_low(ee_scl_low), .ee_sda_low(ee_sda_low), .ee_scl_in(ee_scl_in),
    .ee_sda_in(ee_sda_in), .otg_role_id_pin(otg_role_id_pin), .port1_role(port1_role),
    .port2_role(port2_role), .port1_role_eff(port1_role_eff),
    .port2_role_eff(port2_role_eff), .role_err(role_err), .sel_conflict(sel_conflict));
  gmx_pin_partner i_far (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
                         .ext_val(ext_val), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic clr();
    @(posedge clk);
    {sel_host, sel_fast, sel_spi, sel_uart, sel_eeprom, sel_otg_id} <= 6'h00;
    gpio_dir <= 32'hFFFF_FFFF;
    gpio_out <= 32'h0000_0000;
    {ext_en, ext_val} <= 64'h0000_0000_0000_0000;
    {host_int, fs_rts, fs_txd, spi_master, spi_mosi_out, spi_sck_out} <= 6'h00;
    {spi_miso_out, uart_tx, ee_large, ee_scl_low, ee_sda_low} <= 5'h00;
    host_data_out <= 16'h0000;
    port1_role <= 2'h0;
    port2_role <= 2'h0;
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    repeat (10) @(posedge clk);
    #1;
    `CHK("rst_oe", 32'h0000_0000, pin_oe)
    `CHK("rst_strobes", 3'h7, {host_read_strobe_n, host_write_strobe_n, host_select_n})
    `CHK("rst_idle", 3'h7, {uart_rx, otg_role_id_pin, spi_select_in_n})
  endtask

  task automatic t_gpio();
    clr();
    @(posedge clk);
    gpio_out <= 32'hA5A5_A5A5;
    tick();
    `CHK("gpio_oe", `GMX_PRESENT_MASK, pin_oe)
    `CHK("gpio_out", 32'hA5A5_A5A5 & `GMX_PRESENT_MASK, pin_out)
    `CHK("gpio_avail", `GMX_PRESENT_MASK, gpio_avail)
    `CHK("gpio_count", 6'd25, 6'($countones(gpio_avail)))
    @(posedge clk);
    gpio_dir <= 32'h0000_0000;
    ext_en <= 32'hFFFF_FFFF;
    ext_val <= 32'h5A5A_5A5A;
    tick();
    tick(); // Pads release one cycle after the direction change
    `CHK("gpio_in", 32'h5A5A_5A5A & `GMX_PRESENT_MASK, gpio_in)
    @(posedge clk);
    ext_val <= 32'hA5A5_A5A5;
    tick();
    `CHK("gpio_in2", 32'hA5A5_A5A5 & `GMX_PRESENT_MASK, gpio_in)
  endtask

  task automatic t_serial();
    clr();
    @(posedge clk);
    {sel_uart, uart_tx, sel_fast, sel_spi, spi_master, fs_rts, spi_mosi_out} <= 7'h7F;
    ext_en <= 32'h0000_A340;
    ext_val <= 32'h0000_0100;
    tick();
    `CHK("uart_tx", 2'b11, {pin_oe[7], pin_out[7]})
    `CHK("fs_out", 4'hE, {pin_oe[14], pin_out[14], pin_oe[12], pin_out[12]})
    `CHK("spi_out", 4'hE, {pin_oe[11:10], pin_out[11:10]})
    `CHK("ser_avail", 32'h0000_0000,
         gpio_avail & (`GMX_FAST_MASK | `GMX_SPI_MASK | `GMX_UART_MASK))
    `CHK("ser_noconf", 1'b0, sel_conflict)
    // Inputs show the far side once the GPIO drive has let go
    tick();
    `CHK("uart_rx", 2'b00, {pin_oe[6], uart_rx})
    `CHK("fs_in", 2'b00, {fs_cts, fs_rxd})
    `CHK("spi_in", 2'b10, {spi_miso_in, spi_select_in_n})
  endtask

  task automatic t_spi_slave();
    clr();
    @(posedge clk);
    {sel_spi, spi_miso_out, spi_mosi_out, spi_sck_out} <= 4'hF;
    ext_en <= 32'h0000_0E00;
    ext_val <= 32'h0000_0800;
    tick();
    tick();
    `CHK("slv_drive", 4'h3, {pin_oe[11:10], pin_oe[8], pin_out[8]})
    `CHK("slv_in", 3'h4, {spi_mosi_in, spi_sck_in, spi_select_in_n})
    @(posedge clk);
    ext_val <= 32'h0000_0600;
    tick();
    `CHK("slv_desel", 4'h1, {pin_oe[11:10], pin_oe[8], pin_out[8]})
    `CHK("slv_in2", 3'h3, {spi_mosi_in, spi_sck_in, spi_select_in_n})
  endtask

  task automatic t_host();
    clr();
    @(posedge clk);
    {sel_host, sel_fast, sel_spi, sel_uart, sel_eeprom, sel_otg_id} <= 6'h3F;
    {host_int, ee_scl_low} <= 2'b11;
    host_data_out <= 16'hC3A5;
    ext_en <= 32'h20F8_0000;
    ext_val <= 32'h0050_0000;
    tick();
    `CHK("conflict", 1'b1, sel_conflict)
    `CHK("host_data", 32'hFFFF_C3A5, {pin_oe[15:0], pin_out[15:0]})
    `CHK("host_int", 2'b11, {pin_oe[24], pin_out[24]})
    `CHK("ee_pins", 4'h8, {pin_oe[31:30], pin_out[31:30]})
    `CHK("host_avail", 32'h0000_0000, gpio_avail)
    tick();
    `CHK("host_ctl", 5'h0A, {host_read_strobe_n, host_write_strobe_n, host_select_n,
         host_addr})
    `CHK("otg_id", 1'b0, otg_role_id_pin)
    `CHK("ee_lines", 2'b01, {ee_scl_in, ee_sda_in})
    @(posedge clk);
    ext_en <= 32'h20F8_FFFF;
    ext_val <= 32'h00B0_1234;
    ee_large <= 1'b1;
    tick();
    `CHK("ee_swap", 2'b01, pin_oe[31:30])
    `CHK("host_rel", 16'h0000, pin_oe[15:0])
    tick();
    `CHK("host_wr", 17'h0_1234, {host_write_strobe_n, host_data_in})
    `CHK("host_rd", 1'b1, host_read_strobe_n)
  endtask

  task automatic t_roles();
    clr();
    for (int a = 0; a < 4; a++) begin
      for (int b = 0; b < 4; b++) begin
        @(posedge clk);
        port1_role <= 2'(a);
        port2_role <= 2'(b);
        tick();
        `CHK("p1_eff", 2'(a), port1_role_eff)
        `CHK("p2_eff", (b == 3) ? 2'h0 : 2'(b), port2_role_eff)
        `CHK("role_err", (b == 3) ? 1'b1 : 1'b0, role_err)
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    clr();
    t_reset();
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    tick();
    t_gpio();
    t_serial();
    t_spi_slave();
    t_host();
    t_roles();
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("[ERR] watchdog exp done got hang");
    tally_and_finish();
  end
endmodule // tb_top
